// *** ein_cfg_pkg.sv ***
// Package with command codes, field layouts and limits for the input energy block.
package ein_cfg_pkg;

    // Command codes seen on the command port.
    localparam logic [7:0] CMD_EIN_READ      = 8'hC0;
    localparam logic [7:0] CMD_EIN_CONFIG    = 8'hC1;
    localparam logic [7:0] CMD_GAIN_TC       = 8'hC3;
    localparam logic [7:0] CMD_GAIN          = 8'hE8;
    localparam logic [7:0] CMD_CLEAR_ENERGY  = 8'hCC;

    // Energy configuration byte layout.
    localparam int         CFG_HD_BIT        = 2;
    localparam int         CFG_RANGE_LSB     = 0;
    localparam int         CFG_USED_W        = 3;
    localparam logic [2:0] CFG_RESET         = 3'h0;

    // Register reset values.
    localparam logic [15:0] GAIN_TC_RESET    = 16'h0000;
    localparam logic [15:0] GAIN_RESET       = 16'hBA00;

    // Gain held internally in units of 2^-10 milliohm.
    localparam int          GAIN_FRAC        = 10;
    localparam logic [19:0] GAIN_MIN_Q       = 20'h0000B;
    localparam logic [19:0] GAIN_MAX_Q       = 20'hFA000;

    // Correction factor held in units of 2^-16.
    localparam logic [18:0] TCORR_ONE        = 19'h10000;
    localparam logic [18:0] TCORR_MIN        = 19'h04000;
    localparam logic [18:0] TCORR_MAX        = 19'h40000;

    // Die temperature in 1/16 degree units; 25.0 degrees reference.
    localparam logic signed [16:0] TEMP_REF_Q = 17'sh00190;
    // 1E-6 * 2^16 / 16 is approximated by 4295 / 2^20.
    localparam logic signed [14:0] TC_SCALE   = 15'sh10C7;
    localparam int                 TC_SHIFT   = 20;

    // Current = sense microvolts * 2^26 / (gain_q * tcorr), in milliamps.
    localparam int NUM_SHIFT = 26;
    localparam int NUM_W     = 42;

    typedef enum logic [1:0] {
        RANGE_HIGH,
        RANGE_MEDIUM,
        RANGE_LOW,
        RANGE_RESERVED
    } iin_range_t;

    typedef struct packed {
        logic        valid;
        logic        wr;
        logic [7:0]  code;
        logic [15:0] data;
    } cmd_req_t;

    typedef struct packed {
        logic [47:0] time_ms;
        logic [47:0] energy_mj;
    } energy_snap_t;

endpackage

// *** input_current_energy_config.sv ***
// Input current calculation, energy accumulation and their configuration.
`timescale 1ns/10ps

module input_current_energy_config
    import ein_cfg_pkg::*;
#(
    parameter int NUM_CHAN = 8,
    parameter int CHAN_W   = 3,
    parameter int VIN_CHAN = 6,
    parameter int IIN_CHAN = 7
) (
    input  wire logic               i_mclk,
    input  wire logic               i_rst_n,
    input  wire logic               i_ce,
    input  wire cmd_req_t           i_cmd,
    input  wire logic               i_wp_level2,
    output      logic [15:0]        o_cmd_rdata,
    output      logic               o_cmd_nack,
    input  wire logic               i_adc_next,
    output      logic [CHAN_W-1:0]  o_adc_chan,
    output      iin_range_t         o_iin_range,
    input  wire logic               i_iin_sample,
    input  wire logic signed [15:0] i_iin_sense_uv,
    input  wire logic signed [15:0] i_die_temp,
    output      logic signed [31:0] o_iin_ma,
    output      logic               o_iin_valid,
    input  wire logic               i_acc_update,
    input  wire logic [23:0]        i_energy_delta,
    input  wire logic               i_energy_dec,
    input  wire logic [15:0]        i_time_delta,
    input  wire logic               i_block_read,
    output      energy_snap_t       o_ein_snap
);

    ////////////////////////////////////////////////////////////////////////
    // Helper functions.

    function automatic logic [19:0] gain_q(input logic [15:0] raw);
        logic [39:0] v;
        int          sh;
        v  = {29'h0, raw[10:0]};
        sh = int'($signed(raw[15:11])) + GAIN_FRAC;
        if (raw[10] || raw[10:0] == 11'h000) begin
            return GAIN_MIN_Q;
        end
        if (sh >= 0) begin
            v = v << sh;
        end else begin
            v = v >> (-sh);
        end
        if (v < 40'(GAIN_MIN_Q)) begin
            return GAIN_MIN_Q;
        end
        if (v > 40'(GAIN_MAX_Q)) begin
            return GAIN_MAX_Q;
        end
        return v[19:0];
    endfunction

    function automatic logic is_cmd(input cmd_req_t c, input logic [7:0] k);
        return c.valid && c.code == k;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers and command port.

    logic [CFG_USED_W-1:0] cfg_r;
    logic [15:0]           gain_tc_r;
    logic [15:0]           gain_raw_r;
    logic                  clr_pend_r;
    logic                  wr_cfg;
    logic                  wr_clr;

    // Write protection only guards the stored settings, never the clear.
    assign wr_cfg = is_cmd(i_cmd, CMD_EIN_CONFIG) && i_cmd.wr && !i_wp_level2;
    assign wr_clr = is_cmd(i_cmd, CMD_CLEAR_ENERGY);

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_r      <= CFG_RESET;
            gain_tc_r  <= GAIN_TC_RESET;
            gain_raw_r <= GAIN_RESET;
        end else if (i_ce && i_cmd.valid && i_cmd.wr && !i_wp_level2) begin
            if (i_cmd.code == CMD_EIN_CONFIG) begin
                cfg_r <= i_cmd.data[CFG_USED_W-1:0];
            end
            if (i_cmd.code == CMD_GAIN_TC) begin
                gain_tc_r <= i_cmd.data;
            end
            if (i_cmd.code == CMD_GAIN) begin
                gain_raw_r <= i_cmd.data;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cmd_rdata <= 16'h0000;
            o_cmd_nack  <= 1'b0;
        end else if (i_ce) begin
            o_cmd_nack <= 1'b0;
            if (i_cmd.valid && !i_cmd.wr) begin
                unique case (i_cmd.code)
                    CMD_EIN_CONFIG: o_cmd_rdata <= 16'(cfg_r);
                    CMD_GAIN_TC:    o_cmd_rdata <= gain_tc_r;
                    CMD_GAIN:       o_cmd_rdata <= gain_raw_r;
                    default:        o_cmd_nack  <= 1'b1;
                endcase
            end else if (i_cmd.valid && i_cmd.code != CMD_EIN_CONFIG
                         && i_cmd.code != CMD_GAIN_TC
                         && i_cmd.code != CMD_GAIN
                         && i_cmd.code != CMD_CLEAR_ENERGY) begin
                o_cmd_nack <= 1'b1;
            end
        end
    end

    assign o_iin_range = iin_range_t'(cfg_r[CFG_RANGE_LSB +: 2]);

    ////////////////////////////////////////////////////////////////////////
    // ADC polling order.

    logic [CHAN_W-1:0] seq_idx_r;
    logic              hd_slot_r;
    logic              hd_iin_r;

    // In HD mode every other slot is an input slot, alternating vin and iin.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seq_idx_r  <= '0;
            hd_slot_r  <= 1'b0;
            hd_iin_r   <= 1'b0;
            o_adc_chan <= '0;
        end else if (i_ce && i_adc_next) begin
            if (cfg_r[CFG_HD_BIT] && !hd_slot_r) begin
                o_adc_chan <= hd_iin_r ? CHAN_W'(IIN_CHAN)
                                       : CHAN_W'(VIN_CHAN);
                hd_iin_r   <= !hd_iin_r;
                hd_slot_r  <= 1'b1;
            end else begin
                o_adc_chan <= seq_idx_r;
                hd_slot_r  <= 1'b0;
                seq_idx_r  <= (seq_idx_r == CHAN_W'(NUM_CHAN - 1))
                              ? '0 : seq_idx_r + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Correction factor and current division.

    logic        [19:0]  gain_use;
    logic signed [16:0]  temp_off;
    logic signed [32:0]  tc_prod;
    logic signed [47:0]  tc_delta;
    logic signed [47:0]  tcorr_raw;
    logic        [18:0]  tcorr;

    assign gain_use = gain_q(gain_raw_r);

    always_comb begin
        temp_off  = 17'(i_die_temp) - TEMP_REF_Q;
        tc_prod   = 33'($signed(gain_tc_r)) * 33'(temp_off);
        tc_delta  = (48'(tc_prod) * 48'(TC_SCALE)) >>> TC_SHIFT;
        tcorr_raw = 48'(TCORR_ONE) + tc_delta;
        // Signed limits keep a negative sum from passing as a huge one.
        if (tcorr_raw < $signed(48'(TCORR_MIN))) begin
            tcorr = TCORR_MIN;
        end else if (tcorr_raw > $signed(48'(TCORR_MAX))) begin
            tcorr = TCORR_MAX;
        end else begin
            tcorr = tcorr_raw[18:0];
        end
    end

    logic [NUM_W-1:0] num_r;
    logic [NUM_W-1:0] quo_r;
    logic [39:0]      rem_r;
    logic [38:0]      den_r;
    logic             neg_r;
    logic [5:0]       bit_cnt_r;
    logic             busy_r;
    logic [40:0]      rem_sh;

    // Shift-subtract keeps the divider small; a result takes NUM_W cycles.
    assign rem_sh = {rem_r, num_r[NUM_W-1]};

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            num_r       <= '0;
            quo_r       <= '0;
            rem_r       <= '0;
            den_r       <= '0;
            neg_r       <= 1'b0;
            bit_cnt_r   <= '0;
            busy_r      <= 1'b0;
            o_iin_ma    <= '0;
            o_iin_valid <= 1'b0;
        end else if (i_ce) begin
            o_iin_valid <= 1'b0;
            if (!busy_r && i_iin_sample) begin
                neg_r     <= i_iin_sense_uv[15];
                num_r     <= NUM_W'(i_iin_sense_uv[15] ? -i_iin_sense_uv
                                                       : i_iin_sense_uv)
                             << NUM_SHIFT;
                den_r     <= 39'(gain_use) * 39'(tcorr);
                rem_r     <= '0;
                quo_r     <= '0;
                bit_cnt_r <= 6'(NUM_W);
                busy_r    <= 1'b1;
            end else if (busy_r) begin
                num_r <= num_r << 1;
                if (rem_sh >= 41'(den_r)) begin
                    rem_r <= 40'(rem_sh - 41'(den_r));
                    quo_r <= {quo_r[NUM_W-2:0], 1'b1};
                end else begin
                    rem_r <= rem_sh[39:0];
                    quo_r <= {quo_r[NUM_W-2:0], 1'b0};
                end
                bit_cnt_r <= bit_cnt_r - 1'b1;
                if (bit_cnt_r == 6'h01) begin
                    busy_r <= 1'b0;
                end
            end else if (bit_cnt_r == 6'h00 && quo_r != '0) begin
                o_iin_ma    <= neg_r ? -$signed(32'(quo_r))
                                     : $signed(32'(quo_r));
                o_iin_valid <= 1'b1;
                quo_r       <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Energy and time accumulators.

    logic [47:0] energy_r;
    logic [47:0] time_r;

    // A clear that arrives with an update stays pending: that update still adds, and the next one zeroes.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clr_pend_r <= 1'b0;
        end else if (i_ce) begin
            if (wr_cfg || wr_clr) begin
                clr_pend_r <= 1'b1;
            end else if (i_acc_update) begin
                clr_pend_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            energy_r <= '0;
            time_r   <= '0;
        end else if (i_ce && i_acc_update) begin
            if (clr_pend_r) begin
                energy_r <= '0;
                time_r   <= '0;
            end else begin
                time_r <= time_r + 48'(i_time_delta);
                if (!i_energy_dec) begin
                    energy_r <= energy_r + 48'(i_energy_delta);
                end else if (energy_r < 48'(i_energy_delta)) begin
                    energy_r <= '0;
                end else begin
                    energy_r <= energy_r - 48'(i_energy_delta);
                end
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ein_snap <= '0;
        end else if (i_ce && !i_block_read) begin
            o_ein_snap.energy_mj <= energy_r;
            o_ein_snap.time_ms   <= time_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    cfg_rsvd_zero_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_ce && i_cmd.valid && !i_cmd.wr && i_cmd.code == CMD_EIN_CONFIG
        |=> o_cmd_rdata[15:CFG_USED_W] == '0)
        else $error("Reserved config bits read nonzero.");

    gain_clamp_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        gain_use >= GAIN_MIN_Q && gain_use <= GAIN_MAX_Q)
        else $error("Internal gain outside its limits.");

    gain_readback_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_ce && i_cmd.valid && i_cmd.wr && i_cmd.code == CMD_GAIN
        && !i_wp_level2 ##1 !i_cmd.valid ##1 i_ce && i_cmd.valid
        && !i_cmd.wr && i_cmd.code == CMD_GAIN
        |=> o_cmd_rdata == $past(i_cmd.data, 3))
        else $error("Gain readback differs from last write.");

    tcorr_sat_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        tcorr >= TCORR_MIN && tcorr <= TCORR_MAX)
        else $error("Correction factor outside saturation range.");

    clear_wp_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_ce && i_cmd.valid && i_cmd.code == CMD_CLEAR_ENERGY
        |=> clr_pend_r)
        else $error("Clear command was not taken.");

    clear_apply_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_ce && i_acc_update && clr_pend_r |=> energy_r == '0
        && time_r == '0)
        else $error("Clear command did not zero accumulators.");

    energy_floor_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_ce && i_acc_update && !clr_pend_r && i_energy_dec
        && energy_r < 48'(i_energy_delta) |=> energy_r == '0)
        else $error("Energy decrement went below zero.");

    snap_frozen_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_block_read ##1 i_block_read |-> $stable(o_ein_snap))
        else $error("Snapshot changed during block read.");

    hd_interleave_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_ce && i_adc_next && cfg_r[CFG_HD_BIT] && !hd_slot_r
        |=> o_adc_chan == CHAN_W'(VIN_CHAN)
        || o_adc_chan == CHAN_W'(IIN_CHAN))
        else $error("HD slot did not select an input channel.");

    range_out_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_ce && wr_cfg |=> o_iin_range == iin_range_t'($past(i_cmd.data[1:0])))
        else $error("Range output does not follow configuration.");

endmodule

// *** pmbus_host_model.sv ***
// Host model that issues commands to the energy block and reads answers.
`timescale 1ns/10ps
module pmbus_host_model
    import ein_cfg_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic [15:0] i_rdata,
    output      cmd_req_t    o_cmd
);

    initial o_cmd = '0;

    ////////////////////////////////////////////////////////////////////////
    // A released request shows inverted fields so that stale data is seen.
    task automatic send(input logic wr, input logic [7:0] code,
                        input logic [15:0] data);
        logic [15:0] d;
        d = data;
        // The host keeps away from the reserved range code.
        if (wr && code == CMD_EIN_CONFIG && d[1:0] == 2'h3) begin
            d[1:0] = 2'h2;
        end
        @(posedge i_mclk);
        #1;
        o_cmd = '{1'b1, wr, code, d};
        @(posedge i_mclk);
        #1;
        o_cmd = '{1'b0, ~wr, ~code, ~d};
    endtask

    task automatic read(input logic [7:0] code, output logic [15:0] v);
        send(1'b0, code, 16'h0000);
        @(posedge i_mclk);
        #1;
        v = i_rdata;
    endtask

endmodule

// *** input_current_energy_config_bench.sv ***
// Self-checking bench for the input current and energy block.
`timescale 1ns/10ps
module input_current_energy_config_bench
    import ein_cfg_pkg::*;
;
    logic mclk, rst_n, wp, adc_next, smp, acc_upd, e_dec, blk_rd, nack, vld;
    logic signed [15:0] sense, temp;
    logic signed [31:0] iin_ma;
    logic [23:0]  e_delta;
    logic [15:0]  t_delta, rdata;
    logic [2:0]   chan, prev;
    cmd_req_t     cmd;
    logic         ce;
    iin_range_t   range_o;
    energy_snap_t snap;
    int           failures, checked;

    input_current_energy_config u_dut (
        .i_mclk(mclk), .i_rst_n(rst_n), .i_ce(ce), .i_cmd(cmd),
        .i_wp_level2(wp), .o_cmd_rdata(rdata), .o_cmd_nack(nack),
        .i_adc_next(adc_next), .o_adc_chan(chan), .o_iin_range(range_o),
        .i_iin_sample(smp), .i_iin_sense_uv(sense), .i_die_temp(temp),
        .o_iin_ma(iin_ma), .o_iin_valid(vld), .i_acc_update(acc_upd),
        .i_energy_delta(e_delta), .i_energy_dec(e_dec),
        .i_time_delta(t_delta), .i_block_read(blk_rd), .o_ein_snap(snap));

    pmbus_host_model u_host (.i_mclk(mclk), .i_rdata(rdata), .o_cmd(cmd));

    always #25 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask

    task give_verdict;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] v;
        u_host.read(c, v);
        check({32'h0, v}, {32'h0, e});
    endtask

    task automatic adc_step;
        @(posedge mclk);
        #1;
        adc_next = 1'b1;
        @(posedge mclk);
        #1;
        adc_next = 1'b0;
    endtask

    // The wait is bounded; a missing result leaves a stale value to compare.
    task automatic calc(input logic signed [15:0] s,
                        input logic signed [15:0] t, input logic [31:0] e);
        int n;
        @(posedge mclk);
        #1;
        smp = 1'b1; sense = s; temp = t;
        @(posedge mclk);
        #1;
        smp = 1'b0; sense = ~s; temp = ~t;
        n = 0;
        while (vld !== 1'b1 && n < 60) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check({47'h0, vld}, 48'h1);
        check({16'h0, iin_ma}, {16'h0, e});
    endtask

    task automatic acc(input logic [23:0] d, input logic dec,
                       input logic [15:0] t);
        @(posedge mclk);
        #1;
        acc_upd = 1'b1; e_delta = d; e_dec = dec; t_delta = t;
        @(posedge mclk);
        #1;
        acc_upd = 1'b0; e_delta = ~d; t_delta = ~t;
        @(posedge mclk);
        #1;
    endtask

    task automatic snap_is(input logic [47:0] e, input logic [47:0] t);
        check(snap.energy_mj, e);
        check(snap.time_ms, t);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(50 * 30000);
        failures++;
        give_verdict;
    end

    initial begin
        mclk = 0; rst_n = 0; wp = 0; adc_next = 0; smp = 0; acc_upd = 0;
        e_dec = 0; blk_rd = 0; sense = 0; temp = 0; e_delta = 0; t_delta = 0;
        failures = 0; checked = 0; ce = 1;
        repeat (8) @(posedge mclk);
        #1;
        rst_n = 1;
        for (int k = 0; k < 8; k++) begin
            adc_step();
            check({45'h0, chan}, 48'(k));
        end
        rd(CMD_GAIN, GAIN_RESET);
        rd(CMD_GAIN_TC, GAIN_TC_RESET);
        rd(CMD_EIN_CONFIG, 16'h0000);
        $display("test reset_and_order done");
        u_host.send(1'b1, CMD_EIN_CONFIG, 16'h0004);
        prev = 3'h0;
        for (int k = 0; k < 16; k++) begin
            adc_step();
            // Of any two neighbouring picks one must be input voltage or current.
            check(48'(chan == 3'(6) || chan == 3'(7) || prev == 3'(6)
                      || prev == 3'(7)), 48'h1);
            prev = chan;
        end
        u_host.send(1'b1, CMD_EIN_CONFIG, 16'hFFFA);
        rd(CMD_EIN_CONFIG, 16'h0002);
        for (int k = 0; k < 3; k++) begin
            u_host.send(1'b1, CMD_EIN_CONFIG, 16'(k));
            check({46'h0, range_o}, 48'(k));
        end
        u_host.send(1'b1, CMD_EIN_READ, 16'h0000);
        check({47'h0, nack}, 48'h1);
        $display("test config done");
        calc(16'sd1000, 16'sh0190, 32'd1000);
        u_host.send(1'b1, CMD_GAIN_TC, 16'h2710);
        calc(16'sd1000, 16'sh07D0, 32'd500);
        u_host.send(1'b1, CMD_GAIN_TC, 16'h7FFF);
        calc(16'sd4000, 16'sh7FF0, 32'd1000);
        u_host.send(1'b1, CMD_GAIN_TC, 16'h8000);
        rd(CMD_GAIN_TC, 16'h8000);
        calc(16'sd4000, 16'sh7FF0, 32'd16000);
        u_host.send(1'b1, CMD_GAIN_TC, 16'h0000);
        ce = 1'b0;
        u_host.send(1'b1, CMD_GAIN_TC, 16'h1111);
        ce = 1'b1;
        rd(CMD_GAIN_TC, 16'h0000);
        u_host.send(1'b1, CMD_GAIN, 16'h7BFF);
        rd(CMD_GAIN, 16'h7BFF);
        calc(16'sd30000, 16'sh0190, 32'd30);
        u_host.send(1'b1, CMD_GAIN, 16'h8001);
        calc(16'sd11, 16'sh0190, 32'd1024);
        wp = 1'b1;
        u_host.send(1'b1, CMD_GAIN, 16'h1234);
        rd(CMD_GAIN, 16'h8001);
        $display("test current done");
        acc(24'd77, 1'b0, 16'd7);
        acc(24'd77, 1'b0, 16'd7);
        snap_is(48'd77, 48'd7);
        // The clear waits for the next update, which it swallows whole.
        u_host.send(1'b1, CMD_CLEAR_ENERGY, 16'h0000);
        acc(24'd77, 1'b0, 16'd7);
        snap_is(48'd0, 48'd0);
        wp = 1'b0;
        acc(24'd100, 1'b0, 16'd10);
        acc(24'd200, 1'b0, 16'd20);
        snap_is(48'd300, 48'd30);
        blk_rd = 1'b1;
        acc(24'd50, 1'b0, 16'd5);
        snap_is(48'd300, 48'd30);
        blk_rd = 1'b0;
        acc(24'd1, 1'b0, 16'd1);
        snap_is(48'd351, 48'd36);
        acc(24'd400, 1'b1, 16'd1);
        snap_is(48'd0, 48'd37);
        acc(24'd9, 1'b0, 16'd3);
        u_host.send(1'b1, CMD_CLEAR_ENERGY, 16'h0000);
        acc(24'd5, 1'b0, 16'd5);
        snap_is(48'd0, 48'd0);
        acc(24'd6, 1'b0, 16'd6);
        u_host.send(1'b1, CMD_EIN_CONFIG, 16'h0000);
        acc(24'd5, 1'b0, 16'd5);
        snap_is(48'd0, 48'd0);
        acc(24'd5, 1'b0, 16'd5);
        snap_is(48'd5, 48'd5);
        $display("test energy done");
        give_verdict;
    end

endmodule
